// *** src/ocp_map.vh ***
`ifndef OCP_MAP_VH
`define OCP_MAP_VH
// ************************************************************
// Register byte offsets.
// ************************************************************
`define OCP_CTRL      8'h00
`define OCP_HDR29     8'h04
`define OCP_HDR11     8'h08
`define OCP_PRIO      8'h0C
`define OCP_REQ_LO    8'h10
`define OCP_REQ_HI    8'h14
`define OCP_STATUS    8'h18
`define OCP_RESP_LO   8'h1C
`define OCP_RESP_HI   8'h20
`define OCP_RESP_ID   8'h24
// ************************************************************
// Field positions.
// ************************************************************
`define OCP_CTRL_FALLBACK 4
`define OCP_CTRL_SHOW_ID  5
// ************************************************************
// Reset values and protocol constants.
// ************************************************************
`define OCP_PRIO_RST      8'h18
`define OCP_HDR24_RST     24'hDB33F1
`define OCP_ID11_RST      11'h7DF
`define OCP_PROTO_AUTO    4'h0
`define OCP_PROTO_FIRST   4'h6
`define OCP_PROTO_LAST    4'hF
`define OCP_STD_MODE      8'h01
`define OCP_STD_PID       8'h00
`define OCP_STD_PCI       8'h02
// ************************************************************
// Timing.
// ************************************************************
`define OCP_CLK_MHZ       200
`define OCP_RESP_WAIT_US  50000
`endif

// *** src/ocp_id_builder.v ***
`timescale 1ns/1ps
`include "ocp_map.vh"

// Builds the transmit identifier from the held header fields or the defaults.
module ocp_id_builder (
  input  wire        use_default,
  input  wire        ext,
  input  wire [7:0]  prio,
  input  wire [23:0] hdr24,
  input  wire [10:0] id11,
  output reg  [28:0] id
);

  // Full default header word; its top three bits are cut off below.
  localparam [31:0] DEF_EXT = {`OCP_PRIO_RST, `OCP_HDR24_RST};

  // Defaults stand in for host headers while searching; only five priority bits fit.
  always @* begin
    if (use_default) begin
      if (ext) begin
        id = DEF_EXT[28:0]; // [R3]
      end else begin
        id = {18'h00000, `OCP_ID11_RST}; // [R17]
      end
    end else if (ext) begin
      id = {prio[4:0], hdr24}; // [R12]
    end else begin
      id = {18'h00000, id11}; // [R16]
    end
  end

endmodule // ocp_id_builder

// *** src/ocp_top.v ***
`timescale 1ns/1ps
`include "ocp_map.vh"

// Overview of operation
// [R1] Protocol zero searches at the next request.
// [R2] Search climbs from protocol six; never send 1-5.
// [R3] Searching ignores host headers, uses defaults.
// [R4] Searching sends mode 01 PID 00.
// [R5] Fixed or fallback tries host data first.
// [R6] Found protocol becomes default, search stays possible; code adopts it only for searches started from protocol zero.
// [R7] Responses hide identifier unless display enabled.
// [R8] Checksum never appears in responses.
// [R9] Device builds identifier and checksum itself.
// [R10] Frame is identifier plus eight data bytes.
// [R11] Four-byte header drops top three bits.
// [R12] Priority byte plus three header bytes combine.
// [R13] Priority byte resets to 18 hex.
// [R14] Host picks DB functional, DA physical type.
// [R15] Functional target 33, source F1.
// [R16] Three-digit header keeps eleven low bits.
// [R17] Standard functional request uses identifier 7DF.
// [R18] Protocol number picks identifier length and rate.
// [R19] Protocol selection stored to nonvolatile immediately.
// [R20] Each configuration command answered with OK.
// [R21] New header used until changed again.
module ocp_top #(
  parameter RESP_WAIT_CYC = `OCP_RESP_WAIT_US * `OCP_CLK_MHZ
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg         tx_valid,
  input  wire        tx_ready,
  output reg  [28:0] tx_id,
  output reg         tx_ext,
  output reg  [63:0] tx_data,
  output reg  [3:0]  tx_proto,
  input  wire        rx_valid,
  input  wire [28:0] rx_id,
  input  wire [3:0]  rx_dlc,
  input  wire [63:0] rx_data,
  output reg         host_ok,
  output reg         nv_store,
  output reg  [4:0]  nv_proto
);

  // ************************************************************
  // States and helpers.
  // ************************************************************
  localparam [1:0] S_IDLE = 2'd0;
  localparam [1:0] S_SEND = 2'd1;
  localparam [1:0] S_WAIT = 2'd2;
  localparam [23:0] WAIT_CYC = RESP_WAIT_CYC[23:0];

  // Protocols 7, 9, A and D carry 29-bit identifiers.
  function is_ext;
    input [3:0] p;
    begin
      is_ext = (p == 4'h7) || (p == 4'h9) || (p == 4'hA) || (p == 4'hD); // [R18]
    end
  endfunction

  // Byte-lane merge for AXI write strobes.
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  st;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (st[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  // ************************************************************
  // Register state.
  // ************************************************************
  reg  [3:0]  proto_reg;
  reg         fallback_reg;
  reg         show_id_reg;
  reg  [7:0]  prio_reg;
  reg  [23:0] hdr24_reg;
  reg  [10:0] id11_reg;
  reg  [31:0] req_lo_reg;
  reg  [31:0] req_hi_reg;
  reg  [63:0] resp_data_reg;
  reg  [31:0] resp_id_reg;
  reg         resp_flag_reg;
  reg  [3:0]  resp_dlc_reg;
  reg         no_data_reg;
  reg         found_reg;
  reg  [1:0]  state_reg;
  reg  [3:0]  try_reg;
  reg         search_reg;
  reg  [23:0] wait_reg;
  reg  [7:0]  aw_addr_reg;
  reg         aw_full_reg;
  reg  [31:0] w_data_reg;
  reg  [3:0]  w_strb_reg;
  reg         w_full_reg;
  wire [28:0] built_id;
  wire        load_search;
  wire [3:0]  load_proto;

  wire        do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
  wire        busy     = (state_reg != S_IDLE);
  wire        go       = do_write && (aw_addr_reg == `OCP_REQ_HI) && !busy;
  wire        fail_now = (state_reg == S_WAIT) && (wait_reg == WAIT_CYC);
  wire        rx_take  = (state_reg == S_WAIT) && rx_valid;
  wire        cfg_addr = (aw_addr_reg == `OCP_CTRL) || (aw_addr_reg == `OCP_HDR29) ||
                         (aw_addr_reg == `OCP_HDR11) || (aw_addr_reg == `OCP_PRIO);
  wire        wr_ok    = cfg_addr || (aw_addr_reg == `OCP_REQ_LO) || go;
  wire [31:0] ctrl_new = merge({26'h0, show_id_reg, fallback_reg, proto_reg},
                               w_data_reg, w_strb_reg);
  wire [31:0] hdr_new  = merge({prio_reg, hdr24_reg}, w_data_reg, w_strb_reg);
  wire [31:0] id11_new = merge({21'h0, id11_reg}, w_data_reg, w_strb_reg);
  wire        rd_resp  = s_axi_arvalid && s_axi_arready && (s_axi_araddr == `OCP_RESP_LO);

  // Next attempt: a search either starts fresh or steps to the next protocol.
  assign load_search = (state_reg == S_IDLE) ? (proto_reg == `OCP_PROTO_AUTO) : 1'b1; // [R1]
  assign load_proto  = (state_reg == S_IDLE) ?
                       ((proto_reg == `OCP_PROTO_AUTO) ? `OCP_PROTO_FIRST : proto_reg) :
                       (search_reg ? try_reg + 4'h1 : `OCP_PROTO_FIRST); // [R2]

  ocp_id_builder u_id (
    .use_default (load_search),
    .ext         (is_ext(load_proto)),
    .prio        (prio_reg),
    .hdr24       (hdr24_reg),
    .id11        (id11_reg),
    .id          (built_id)
  );

  // ************************************************************
  // AXI4-Lite write channel.
  // ************************************************************
  // Address and data are latched independently so either may come first.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg   <= 1'b0;
      w_full_reg    <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h00000000;
      w_strb_reg    <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else begin
      s_axi_awready <= !aw_full_reg && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_full_reg && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Configuration registers.
  // ************************************************************
  // The search engine also writes the protocol field, so both live in one process.
  always @(posedge aclk) begin
    if (!aresetn) begin
      proto_reg    <= `OCP_PROTO_AUTO;
      fallback_reg <= 1'b0;
      show_id_reg  <= 1'b0;
      prio_reg     <= `OCP_PRIO_RST; // [R13]
      hdr24_reg    <= `OCP_HDR24_RST;
      id11_reg     <= `OCP_ID11_RST;
      req_lo_reg   <= 32'h00000000;
      req_hi_reg   <= 32'h00000000;
      host_ok      <= 1'b0;
      nv_store     <= 1'b0;
      nv_proto     <= 5'h00;
    end else begin
      host_ok  <= do_write && cfg_addr; // [R20]
      nv_store <= do_write && (aw_addr_reg == `OCP_CTRL); // [R19]
      if (do_write && aw_addr_reg == `OCP_CTRL) begin
        proto_reg    <= ctrl_new[3:0];
        fallback_reg <= ctrl_new[`OCP_CTRL_FALLBACK];
        show_id_reg  <= ctrl_new[`OCP_CTRL_SHOW_ID];
        nv_proto     <= ctrl_new[4:0]; // [R19]
      end else if (rx_take && search_reg && proto_reg == `OCP_PROTO_AUTO) begin
        proto_reg    <= try_reg; // [R6]
        fallback_reg <= 1'b1; // [R6]
      end
      // Stored header fields persist until rewritten.
      if (do_write && aw_addr_reg == `OCP_HDR29) begin
        prio_reg  <= hdr_new[31:24]; // [R11]
        hdr24_reg <= hdr_new[23:0]; // [R21]
      end
      if (do_write && aw_addr_reg == `OCP_PRIO && w_strb_reg[0]) begin
        prio_reg <= w_data_reg[7:0]; // [R12]
      end
      if (do_write && aw_addr_reg == `OCP_HDR11) begin
        id11_reg <= id11_new[10:0]; // [R16]
      end
      if (do_write && aw_addr_reg == `OCP_REQ_LO) begin
        req_lo_reg <= merge(req_lo_reg, w_data_reg, w_strb_reg);
      end
      if (go) begin
        req_hi_reg <= merge(req_hi_reg, w_data_reg, w_strb_reg);
      end
    end
  end

  // ************************************************************
  // Request, search and response engine.
  // ************************************************************
  // Frames carry the identifier and eight bytes; the controller appends the CRC.
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg     <= S_IDLE;
      try_reg       <= `OCP_PROTO_FIRST;
      search_reg    <= 1'b0;
      wait_reg      <= 24'h000000;
      tx_valid      <= 1'b0;
      tx_id         <= 29'h00000000;
      tx_ext        <= 1'b0;
      tx_data       <= 64'h0000000000000000;
      tx_proto      <= 4'h0;
      resp_data_reg <= 64'h0000000000000000;
      resp_id_reg   <= 32'h00000000;
      resp_dlc_reg  <= 4'h0;
      resp_flag_reg <= 1'b0;
      no_data_reg   <= 1'b0;
      found_reg     <= 1'b0;
    end else begin
      if (rd_resp) begin
        resp_flag_reg <= 1'b0;
      end
      case (state_reg)
        S_IDLE: begin
          if (go && proto_reg != `OCP_PROTO_AUTO && proto_reg < `OCP_PROTO_FIRST) begin
            no_data_reg <= 1'b1; // [R2]
          end else if (go) begin
            no_data_reg <= 1'b0;
            found_reg   <= 1'b0;
            state_reg   <= S_SEND;
          end
        end
        S_SEND: begin
          if (tx_valid && tx_ready) begin
            tx_valid  <= 1'b0;
            wait_reg  <= 24'h000000;
            state_reg <= S_WAIT;
          end
        end
        S_WAIT: begin
          wait_reg <= wait_reg + 24'h000001;
          if (rx_take) begin
            found_reg     <= search_reg;
            resp_flag_reg <= 1'b1;
            state_reg     <= S_IDLE;
            if (show_id_reg) begin
              // The length code goes to STATUS so that all 29 identifier bits fit here.
              resp_data_reg <= rx_data; // [R7]
              resp_id_reg   <= {3'b000, rx_id}; // [R7]
              resp_dlc_reg  <= rx_dlc; // [R7]
            end else begin
              resp_data_reg <= {rx_data[55:0], 8'h00}; // [R7]
              resp_id_reg   <= 32'h00000000;
              resp_dlc_reg  <= 4'h0;
            end
          end else if (fail_now) begin
            if ((search_reg && try_reg == `OCP_PROTO_LAST) || (!search_reg && !fallback_reg)) begin
              no_data_reg <= 1'b1;
              state_reg   <= S_IDLE; // [R5]
            end else begin
              state_reg <= S_SEND; // [R5]
            end
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
      // Load a fresh frame whenever an attempt is about to be sent.
      if ((state_reg == S_IDLE && go && !(proto_reg != `OCP_PROTO_AUTO &&
           proto_reg < `OCP_PROTO_FIRST)) || (state_reg == S_WAIT && fail_now && !rx_take &&
           !((search_reg && try_reg == `OCP_PROTO_LAST) || (!search_reg && !fallback_reg)))) begin
        search_reg <= load_search;
        try_reg    <= load_proto;
        tx_proto   <= load_proto; // [R18]
        tx_ext     <= is_ext(load_proto);
        tx_id      <= built_id; // [R9]
        tx_valid   <= 1'b1;
        if (load_search) begin
          tx_data <= {`OCP_STD_PCI, `OCP_STD_MODE, `OCP_STD_PID, 40'h0}; // [R4]
        end else if (state_reg == S_IDLE) begin
          tx_data <= {5'h00, w_data_reg[26:24], req_lo_reg, w_data_reg[23:0]}; // [R10]
        end else begin
          tx_data <= {5'h00, req_hi_reg[26:24], req_lo_reg, req_hi_reg[23:0]}; // [R10]
        end
      end
    end
  end

  // ************************************************************
  // AXI4-Lite read channel.
  // ************************************************************
  // One read at a time; the checksum never enters any readable field.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'b00;
        case ({s_axi_araddr[7:2], 2'b00})
          `OCP_CTRL:    s_axi_rdata <= {26'h0, show_id_reg, fallback_reg, proto_reg};
          `OCP_HDR29:   s_axi_rdata <= {prio_reg, hdr24_reg};
          `OCP_HDR11:   s_axi_rdata <= {21'h0, id11_reg};
          `OCP_PRIO:    s_axi_rdata <= {24'h0, prio_reg};
          `OCP_REQ_LO:  s_axi_rdata <= req_lo_reg;
          `OCP_REQ_HI:  s_axi_rdata <= req_hi_reg;
          `OCP_STATUS:  s_axi_rdata <= {10'h000, state_reg, try_reg, resp_dlc_reg, resp_flag_reg,
                                        no_data_reg, found_reg, search_reg && busy,
                                        busy, fallback_reg, 2'b00, proto_reg};
          `OCP_RESP_LO: s_axi_rdata <= resp_data_reg[63:32]; // [R8]
          `OCP_RESP_HI: s_axi_rdata <= resp_data_reg[31:0];
          `OCP_RESP_ID: s_axi_rdata <= resp_id_reg;
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b11;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // ocp_top

// *** dv/ocp_ecu_model.sv ***
`timescale 1ns/1ps
// ****
// Far-side node: takes frames after a stall and replies on one protocol only.
// ****
module ocp_ecu_model (
  input  wire         aclk,
  input  wire         tx_valid,
  output logic        tx_ready = 1'b0,
  input  wire  [28:0] tx_id,
  input  wire         tx_ext,
  input  wire  [63:0] tx_data,
  input  wire  [3:0]  tx_proto,
  output logic        rx_valid = 1'b0,
  output logic [28:0] rx_id = 29'h0,
  output logic [3:0]  rx_dlc = 4'h0,
  output logic [63:0] rx_data = 64'h0,
  input  wire  [3:0]  ans,
  input  wire  [1:0]  stall
);
  logic [28:0] log_id [0:63];
  logic [63:0] log_data [0:63];
  logic [3:0]  log_proto [0:63];
  logic        log_ext [0:63];
  logic [28:0] rid = 29'h0;
  int          n_log = 0, cnt = 0, due = 0;
  // Unqualified reply data and identifier lines keep toggling, so stale values never pass for a reply; the length code holds.
  always @(posedge aclk) begin
    tx_ready <= 1'b0;
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
    rx_id <= ~rx_id;
    if (tx_valid && !tx_ready) begin
      cnt <= cnt + 1;
      if (cnt >= stall) begin
        tx_ready <= 1'b1;
        cnt <= 0;
        log_id[n_log] <= tx_id;
        log_data[n_log] <= tx_data;
        log_proto[n_log] <= tx_proto;
        log_ext[n_log] <= tx_ext;
        n_log <= n_log + 1;
        rid <= tx_ext ? 29'h18DAF110 : 29'h7E8;
        if (tx_proto == ans)
          due <= 4;
      end
    end
    if (due > 0) begin
      due <= due - 1;
      if (due == 1) begin
        rx_valid <= 1'b1;
        rx_dlc <= 4'h8;
        rx_id <= rid;
        rx_data <= 64'h064100BE3FB81300;
      end
    end
  end
endmodule // ocp_ecu_model

// *** dv/ocp_top_props.sv ***
`timescale 1ns/1ps
// ****
// Checker on the top ports.
// ****
module ocp_top_props (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_bvalid,
  input wire [1:0]  s_axi_bresp,
  input wire        tx_valid,
  input wire        tx_ready,
  input wire [28:0] tx_id,
  input wire        tx_ext,
  input wire [63:0] tx_data,
  input wire [3:0]  tx_proto,
  input wire        host_ok,
  input wire        nv_store
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // A frame holds still until taken, then is withdrawn at once.
  AST_TX_HOLD: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable({tx_id, tx_ext, tx_data, tx_proto}))
    else $error("frame changed while offered");
  AST_TX_DROP: assert property (
    tx_valid && tx_ready |=> !tx_valid) else $error("frame offered twice");
  AST_NO_OLD: assert property (
    tx_valid |-> tx_proto >= 4'h6) else $error("frame on an unsupported protocol");
  AST_STD_ID: assert property (
    tx_valid && !tx_ext |-> tx_id[28:11] == 18'h0) else $error("standard id too wide");
  AST_EXT: assert property (
    tx_valid |-> tx_ext == (tx_proto inside {4'h7, 4'h9, 4'hA, 4'hD}))
    else $error("id length does not match protocol");
  AST_PCI: assert property (
    tx_valid |-> tx_data[63:56] <= 8'h07) else $error("control byte out of range");
  // The OK pulse marks an accepted write only, so a refused one never gets it.
  AST_OK: assert property (
    host_ok |-> $rose(s_axi_bvalid) && s_axi_bresp == 2'b00) else $error("stray OK");
  AST_NV: assert property (
    nv_store |-> host_ok) else $error("store without accepted command");
endmodule // ocp_top_props

bind ocp_top ocp_top_props u_props (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bresp, .tx_valid,
  .tx_ready, .tx_id, .tx_ext, .tx_data, .tx_proto, .host_ok, .nv_store);

// *** dv/ocp_top_test.sv ***
`timescale 1ns/1ps
`include "ocp_map.vh"
// ****
// Bench for protocol search and identifier assembly.
// ****
module ocp_top_test;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, v;
  logic [3:0]  s_axi_wstrb = 4'hF, ans = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [1:0]  stall = 2'd1, vr = 2'b00;
  logic [4:0]  nv_seen = 5'h1F;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         tx_valid, tx_ready, tx_ext, rx_valid, host_ok, nv_store;
  wire  [28:0] tx_id, rx_id;
  wire  [63:0] tx_data, rx_data;
  wire  [3:0]  tx_proto, rx_dlc;
  wire  [4:0]  nv_proto;
  int          mismatches = 0, n_checks = 0, b = 0, n_ok = 0;

  ocp_top #(.RESP_WAIT_CYC(50)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_valid, .tx_ready, .tx_id, .tx_ext,
    .tx_data, .tx_proto, .rx_valid, .rx_id, .rx_dlc, .rx_data, .host_ok, .nv_store, .nv_proto);
  ocp_ecu_model ecu (.aclk, .tx_valid, .tx_ready, .tx_id, .tx_ext, .tx_data, .tx_proto,
    .rx_valid, .rx_id, .rx_dlc, .rx_data, .ans, .stall);

  // Clock, store monitor and watchdog.
  initial forever #2.5 aclk = ~aclk;
  always @(posedge aclk) if (nv_store) nv_seen <= nv_proto;
  always @(posedge aclk) if (host_ok) n_ok <= n_ok + 1;
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    conclude();
  end

  task automatic conclude;
    if (mismatches == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input [63:0] got, input [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Address and data are released on their own handshakes, whichever comes first.
  task automatic wr(input [7:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (!s_axi_wready);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk({62'h0, s_axi_bresp}, {62'h0, er});
    @(posedge aclk);
  endtask
  task automatic rd(input [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    v = s_axi_rdata;
    vr = s_axi_rresp;
    @(posedge aclk);
  endtask
  task automatic rdc(input [7:0] a, input [31:0] e, input [1:0] er);
    rd(a);
    chk({30'h0, vr, v}, {30'h0, er, e});
  endtask
  // Starts a request and waits for the block to go idle; ans picks the replying protocol.
  task automatic req(input [3:0] p, input [2:0] n);
    ans <= p;
    b = ecu.n_log;
    wr(`OCP_REQ_LO, 32'h01050000, 4'hF, 2'b00);
    wr(`OCP_REQ_HI, {5'h0, n, 24'h0}, 4'hF, 2'b00);
    do rd(`OCP_STATUS); while (v[7]);
  endtask
  task automatic fr(input int i, input [3:0] p, input [28:0] id, input [23:0] d);
    chk({6'h0, ecu.log_proto[b+i], ecu.log_id[b+i], ecu.log_ext[b+i], ecu.log_data[b+i][63:40]},
      {6'h0, p, id, p inside {4'h7, 4'h9, 4'hA, 4'hD}, d});
  endtask

  // Main sequence.
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rdc(`OCP_CTRL, 32'h0, 2'b00);
    rdc(`OCP_PRIO, 32'h18, 2'b00);
    rdc(`OCP_HDR29, 32'h18DB33F1, 2'b00);
    rdc(`OCP_HDR11, 32'h7DF, 2'b00);
    rdc(8'h30, 32'h0, 2'b11);
    wr(8'h30, 32'h1, 4'hF, 2'b10);
    wr(`OCP_HDR11, 32'hF7E0, 4'hF, 2'b00);
    wr(`OCP_CTRL, 32'h0, 4'hF, 2'b00);
    chk(64'(nv_seen), 64'h0);
    req(4'h8, 3'd2);
    chk(64'(ecu.n_log - b), 64'd3);
    for (int i = 0; i < 3; i++)
      fr(i, 4'(6 + i), (i == 1) ? 29'h18DB33F1 : 29'h7DF, 24'h020100);
    rd(`OCP_STATUS);
    chk(64'({v[10:9], v[3:0]}), 64'h18);
    rdc(`OCP_CTRL, 32'h18, 2'b00);
    rdc(`OCP_RESP_LO, 32'h4100BE3F, 2'b00);
    rdc(`OCP_RESP_HI, 32'hB8130000, 2'b00);
    rdc(`OCP_RESP_ID, 32'h0, 2'b00);
    // A second start while the first is still under way must be refused.
    stall <= 2'd3;
    ans <= 4'h7;
    b = ecu.n_log;
    wr(`OCP_REQ_LO, 32'h01050000, 4'hF, 2'b00);
    wr(`OCP_REQ_HI, 32'h02000000, 4'hF, 2'b00);
    wr(`OCP_REQ_HI, 32'h02000000, 4'hF, 2'b10);
    do rd(`OCP_STATUS); while (v[7]);
    fr(0, 4'h8, 29'h7E0, 24'h020105);
    fr(1, 4'h6, 29'h7DF, 24'h020100);
    fr(2, 4'h7, 29'h18DB33F1, 24'h020100);
    stall <= 2'd0;
    wr(`OCP_CTRL, 32'h26, 4'hF, 2'b00);
    chk(64'(nv_seen), 64'h06);
    req(4'h9, 3'd2);
    chk(64'(ecu.n_log - b), 64'd1);
    rd(`OCP_STATUS);
    chk(64'(v[10]), 64'h1);
    req(4'h6, 3'd2);
    fr(0, 4'h6, 29'h7E0, 24'h020105);
    rdc(`OCP_RESP_LO, 32'h064100BE, 2'b00);
    rdc(`OCP_RESP_ID, 32'h000007E8, 2'b00);
    rd(`OCP_STATUS);
    chk(64'(v[15:12]), 64'h8);
    wr(`OCP_CTRL, 32'h3, 4'hF, 2'b00);
    req(4'h3, 3'd2);
    chk(64'(ecu.n_log - b), 64'd0);
    wr(`OCP_HDR29, 32'hFFDA10F1, 4'hF, 2'b00);
    wr(`OCP_CTRL, 32'h7, 4'hF, 2'b00);
    req(4'h7, 3'd2);
    fr(0, 4'h7, 29'h1FDA10F1, 24'h020105);
    wr(`OCP_PRIO, 32'h18, 4'h1, 2'b00);
    req(4'h7, 3'd2);
    fr(0, 4'h7, 29'h18DA10F1, 24'h020105);
    chk(64'(n_ok), 64'd7);
    conclude();
  end
endmodule // ocp_top_test
